// file: include/iel_defs.svh
/*
  Offsets, field positions, widths and reset values of the error
  detect and log block. Assumes a 12-bit APB byte address.
*/
`ifndef IEL_DEFS_SVH
`define IEL_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IEL_OFF_IMU_PRI 12'h000
`define IEL_OFF_IMU_SEC 12'h004
`define IEL_OFF_IMU_MASK 12'h008
`define IEL_OFF_CTRL 12'h00C
`define IEL_OFF_EQ 12'h010
`define IEL_OFF_MMU_STS 12'h014
`define IEL_OFF_MMU_MASK 12'h018
`define IEL_OFF_FADDR_LO 12'h01C
`define IEL_OFF_FADDR_HI 12'h020
`define IEL_OFF_FSTS 12'h024
`define IEL_OFF_RDS0 12'h028
`define IEL_OFF_RDS1 12'h02C
`define IEL_OFF_RDS2 12'h030
`define IEL_OFF_SCS0 12'h034
`define IEL_OFF_SCS1 12'h038
`define IEL_OFF_SCS2 12'h03C
`define IEL_OFF_ADJ_BASE 12'h040
`define IEL_OFF_FATAL 12'h044

// ----------------------------------------------------------------
// Interrupt-unit status bit positions (secondary = primary + 32)
// ----------------------------------------------------------------
`define IEL_IMU_W 10
`define IEL_B_MSI_OFF 0
`define IEL_B_COR_OFF 1
`define IEL_B_NONFATAL_OFF 2
`define IEL_B_FATAL_OFF 3
`define IEL_B_PMEACK_OFF 5
`define IEL_B_MSI_PAR 6
`define IEL_B_MSI_MAL 7
`define IEL_B_EQ_OFF 8
`define IEL_B_EQ_OVF 9

// ----------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------
`define IEL_C_MSI_EN 0
`define IEL_C_COR_EN 1
`define IEL_C_NONFATAL_EN 2
`define IEL_C_FATAL_EN 3
`define IEL_C_PME_EN 4
`define IEL_C_PMEACK_EN 5
`define IEL_C_BYP_EN 8
`define IEL_C_HYPER 9
`define IEL_CTRL_RESET 32'h0000_0000

// ----------------------------------------------------------------
// Translation-unit status bits and address fields
// ----------------------------------------------------------------
`define IEL_MMU_W 6
`define IEL_M_BYP_ERR 0
`define IEL_M_BYP_OOR 1
`define IEL_M_DESC_INV 2
`define IEL_M_DESC_PAR 3
`define IEL_M_VA_OOR 4
`define IEL_M_ADJ_UF 5
`define IEL_VA_W 40
`define IEL_VA_OOR_HI 62
`define IEL_VA_OOR_LO 40

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define IEL_EQ_N 8
`define IEL_EQ_IW 3
`define IEL_COMPLETION_TAG_FIELD_W 13
`define IEL_COMPLETION_TAG_FIELD_SW 4
`define IEL_TAG_W 8
`define IEL_ACK_W 8
`define IEL_FATAL_COMPLETION_TAG_FIELD 0
`define IEL_FATAL_ACK 1

`endif

// file: include/iel_pkg.sv
/*
  Types of the error detect and log block.
  Assumes iel_defs.svh is on the include path.
*/
`include "iel_defs.svh"

package iel_pkg;

  // ----------------------------------------------------------------
  // Message classes and event queue states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IEL_MSG_COR, IEL_MSG_NONFATAL, IEL_MSG_FATAL, IEL_MSG_PME, IEL_MSG_PMEACK, IEL_MSG_OTHER
  } iel_msg_type;

  typedef enum logic {IEL_EQ_ACTIVE, IEL_EQ_ERROR} iel_eq_state_type;

  // ----------------------------------------------------------------
  // Transaction carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ttype;
    logic [9:0] len;
    logic [15:0] req_id;
    logic [7:0] tag;
    logic [7:0] be;
    logic [31:0] data;
  } iel_log_type;

  typedef struct packed {
    logic is_msi;
    iel_msg_type msg;
    logic [`IEL_EQ_IW-1:0] eq;
    logic par_err;
    logic malformed;
    logic eq_ovf;
    iel_log_type info;
  } iel_imu_txn_type;

  typedef struct packed {
    logic is_null;
    iel_imu_txn_type txn;
  } iel_imu_out_type;

  typedef struct packed {
    logic [63:0] va;
    logic [15:0] id;
    logic [6:0] ttype;
    logic is_read;
    logic bypass;
    logic desc_inv;
    logic desc_par;
  } iel_xl_req_type;

endpackage

// file: hdl/iel_error_log.sv
/*
  Error detect and log block of the I/O data unit: interrupt-unit
  checks with null conversion, translation-unit fault logging,
  completion tag ECC and acknowledge parity on the return switch.
  Assumes all event inputs are one-cycle pulses synchronous to I_MCLK,
  a zero-wait APB master, and that warm reset drives I_RESET_N.
*/
// The register addresses and the APB interface to the registers were chosen for this implementation.
`include "iel_defs.svh"

// How it works
// - Tag ECC: fix single-bit errors; uncorrectable drops packet and credit, fatal.
// - Acknowledge parity error drops credit return to interrupt unit; fatal.
// - MSI while disabled sets bit 0 or 32 and logs to receive log.
// - MSI data parity sets bit 6 or 38, logs to receive log.
// - Malformed MSI sets bit 7 or 39, logs to receive log.
// - Rejected MSI or message leaves in order as a null transaction.
// - Disabled correctable message sets bit 1 or 33 and logs.
// - Disabled nonfatal message sets bit 2 or 34 and logs.
// - Disabled fatal message sets bit 3 or 35 and logs.
// - Disabled power-management event message sets bit 1 or 33 and logs.
// - Disabled turn-off acknowledge sets bit 5 or 37 and logs.
// - Write to disabled event queue sets bit 8 or 40, status log.
// - Queue overflow sets bit 9 or 41, no log, queue goes ERROR.
// - Every recorded interrupt-unit or translation-unit error raises a maskable interrupt.
// - Bypass access with bypass disabled sets bypass error, logs address, ID, type.
// - Legacy model only: bypass address out of range sets its bit and logs.
// - Any translation fault aborts: writes dropped, reads completer abort.
// - Hypervisor model: invalid descriptor sets bit, logs adjusted address.
// - Hypervisor model: descriptor parity sets bit, logs adjusted address.
// - Hypervisor model: address bits 62:40 nonzero sets range bit, logs.
// - Hypervisor model: adjusted address underflow sets bit, logs.
// - Tag ECC error sends a correctable or an uncorrectable indication to the noncacheable hub.
module iel_error_log (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Interrupt pipeline in and out
  input wire logic I_IMU_VALID,
  input wire iel_pkg::iel_imu_txn_type I_IMU_TXN,
  output logic O_IMU_VALID,
  output iel_pkg::iel_imu_out_type O_IMU_TXN,
  // Completion tag from the return path
  input wire logic I_COMPLETION_TAG_FIELD_VALID,
  input wire logic [`IEL_COMPLETION_TAG_FIELD_W-1:0] I_COMPLETION_TAG_FIELD_CODE,
  output logic O_COMPLETION_TAG_FIELD_VALID,
  output logic [`IEL_TAG_W-1:0] O_COMPLETION_TAG_FIELD,
  output logic O_COMPLETION_TAG_FIELD_CREDIT,
  output logic O_HUB_CE,
  output logic O_HUB_UE,
  // Interrupt acknowledge from the noncacheable hub
  input wire logic I_ACK_VALID,
  input wire logic [`IEL_ACK_W-1:0] I_ACK_DATA,
  input wire logic I_ACK_PARITY,
  output logic O_ACK_CREDIT,
  output logic O_HUB_ACK_ERR,
  // Translation requests
  input wire logic I_XL_VALID,
  input wire iel_pkg::iel_xl_req_type I_XL_REQ,
  output logic O_XL_PASS,
  output logic O_XL_ABORT,
  output logic O_XL_ABORT_READ,
  // Status
  output logic O_IRQ,
  output logic O_FATAL
);

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  wire acc = I_PSEL && I_PENABLE;
  wire wr = acc && I_PWRITE;
  wire hit_pri = I_PADDR == `IEL_OFF_IMU_PRI;
  wire hit_sec = I_PADDR == `IEL_OFF_IMU_SEC;
  wire hit_imask = I_PADDR == `IEL_OFF_IMU_MASK;
  wire hit_ctrl = I_PADDR == `IEL_OFF_CTRL;
  wire hit_eq = I_PADDR == `IEL_OFF_EQ;
  wire hit_msts = I_PADDR == `IEL_OFF_MMU_STS;
  wire hit_mmask = I_PADDR == `IEL_OFF_MMU_MASK;
  wire hit_base = I_PADDR == `IEL_OFF_ADJ_BASE;
  wire hit_ro = I_PADDR inside {`IEL_OFF_FADDR_LO, `IEL_OFF_FADDR_HI, `IEL_OFF_FSTS, `IEL_OFF_RDS0,
    `IEL_OFF_RDS1, `IEL_OFF_RDS2, `IEL_OFF_SCS0, `IEL_OFF_SCS1, `IEL_OFF_SCS2, `IEL_OFF_FATAL};
  wire mapped = hit_pri || hit_sec || hit_imask || hit_ctrl || hit_eq || hit_msts || hit_mmask ||
    hit_base || hit_ro;

  logic [31:0] ctrl;
  logic [`IEL_IMU_W-1:0] imu_mask;
  logic [`IEL_MMU_W-1:0] mmu_mask;
  logic [`IEL_VA_W-1:0] adj_base;
  logic [`IEL_EQ_N-1:0] eq_en;
  iel_pkg::iel_eq_state_type eq_state [`IEL_EQ_N];
  logic [`IEL_EQ_N-1:0] eq_err;
  logic [`IEL_IMU_W-1:0] imu_pri;
  logic [`IEL_IMU_W-1:0] imu_sec;
  logic [`IEL_MMU_W-1:0] mmu_sts;
  logic [63:0] fault_addr;
  logic [31:0] fault_sts;
  iel_pkg::iel_log_type rds_log;
  iel_pkg::iel_log_type scs_log;
  logic [1:0] fatal;

  // ----------------------------------------------------------------
  // Interrupt-unit checks
  // ----------------------------------------------------------------
  iel_pkg::iel_imu_txn_type t;
  assign t = I_IMU_TXN;
  logic msg_off;
  always_comb begin
    case (t.msg)
      iel_pkg::IEL_MSG_COR: msg_off = !ctrl[`IEL_C_COR_EN];
      iel_pkg::IEL_MSG_NONFATAL: msg_off = !ctrl[`IEL_C_NONFATAL_EN];
      iel_pkg::IEL_MSG_FATAL: msg_off = !ctrl[`IEL_C_FATAL_EN];
      iel_pkg::IEL_MSG_PME: msg_off = !ctrl[`IEL_C_PME_EN];
      iel_pkg::IEL_MSG_PMEACK: msg_off = !ctrl[`IEL_C_PMEACK_EN];
      default: msg_off = 1'b0;
    endcase
  end

  // One error per transaction, first check in this order wins
  logic [`IEL_IMU_W-1:0] imu_ev;
  always_comb begin
    imu_ev = '0;
    if (I_IMU_VALID) begin
      if (t.is_msi && !ctrl[`IEL_C_MSI_EN]) begin
        imu_ev[`IEL_B_MSI_OFF] = 1'b1;
      end else if (t.is_msi && t.par_err) begin
        imu_ev[`IEL_B_MSI_PAR] = 1'b1;
      end else if (t.is_msi && t.malformed) begin
        imu_ev[`IEL_B_MSI_MAL] = 1'b1;
      end else if (!t.is_msi && msg_off) begin
        imu_ev[`IEL_B_COR_OFF] = t.msg inside {iel_pkg::IEL_MSG_COR, iel_pkg::IEL_MSG_PME};
        imu_ev[`IEL_B_NONFATAL_OFF] = t.msg == iel_pkg::IEL_MSG_NONFATAL;
        imu_ev[`IEL_B_FATAL_OFF] = t.msg == iel_pkg::IEL_MSG_FATAL;
        imu_ev[`IEL_B_PMEACK_OFF] = t.msg == iel_pkg::IEL_MSG_PMEACK;
      end else if (!eq_en[t.eq]) begin
        imu_ev[`IEL_B_EQ_OFF] = 1'b1;
      end else if (t.eq_ovf) begin
        imu_ev[`IEL_B_EQ_OVF] = 1'b1;
      end
    end
  end
  wire imu_rej = |imu_ev;
  wire log_rds = |imu_ev[`IEL_B_MSI_MAL:`IEL_B_MSI_OFF];
  wire log_scs = imu_ev[`IEL_B_EQ_OFF];

  // ----------------------------------------------------------------
  // Primary and secondary bits, set wins over clear
  // ----------------------------------------------------------------
  wire pri_clr_en = wr && hit_pri;
  wire sec_clr_en = wr && hit_sec;
  genvar gi;
  generate
    for (gi = 0; gi < `IEL_IMU_W; gi++) begin : g_imu
      wire set_pri = imu_ev[gi] && !imu_pri[gi];
      wire set_sec = imu_ev[gi] && imu_pri[gi];
      always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
          imu_pri[gi] <= 1'b0;
          imu_sec[gi] <= 1'b0;
        end else begin
          imu_pri[gi] <= set_pri || (imu_pri[gi] && !(pri_clr_en && I_PWDATA[gi]));
          imu_sec[gi] <= set_sec || (imu_sec[gi] && !(sec_clr_en && I_PWDATA[gi]));
        end
      end
    end
    for (gi = 0; gi < `IEL_EQ_N; gi++) begin : g_eq
      wire ovf = imu_ev[`IEL_B_EQ_OVF] && t.eq == `IEL_EQ_IW'(gi);
      wire rearm = wr && hit_eq && I_PWDATA[gi + `IEL_EQ_N];
      always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
          eq_state[gi] <= iel_pkg::IEL_EQ_ACTIVE;
        end else if (ovf) begin
          eq_state[gi] <= iel_pkg::IEL_EQ_ERROR;
        end else if (rearm) begin
          eq_state[gi] <= iel_pkg::IEL_EQ_ACTIVE;
        end
      end
      assign eq_err[gi] = eq_state[gi] == iel_pkg::IEL_EQ_ERROR;
    end
  endgenerate

  // rejected items leave as null, same order
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_IMU_VALID <= 1'b0;
      O_IMU_TXN <= '0;
    end else begin
      O_IMU_VALID <= I_IMU_VALID;
      O_IMU_TXN <= {imu_rej, I_IMU_TXN};
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rds_log <= '0;
      scs_log <= '0;
    end else begin
      if (log_rds) rds_log <= t.info;
      if (log_scs) scs_log <= t.info;
    end
  end

  // ----------------------------------------------------------------
  // Translation-unit faults
  // ----------------------------------------------------------------
  iel_pkg::iel_xl_req_type x;
  assign x = I_XL_REQ;
  wire hyper = ctrl[`IEL_C_HYPER];
  wire hi_nz = |x.va[`IEL_VA_OOR_HI:`IEL_VA_OOR_LO];
  wire [`IEL_VA_W-1:0] adj_low = x.va[`IEL_VA_W-1:0] - adj_base;
  wire [63:0] adj_va = {x.va[63:`IEL_VA_W], adj_low};
  logic [`IEL_MMU_W-1:0] mmu_ev;
  always_comb begin
    mmu_ev = '0;
    if (I_XL_VALID) begin
      if (x.bypass) begin
        mmu_ev[`IEL_M_BYP_ERR] = !ctrl[`IEL_C_BYP_EN];
        mmu_ev[`IEL_M_BYP_OOR] = ctrl[`IEL_C_BYP_EN] && !hyper && hi_nz;
      end else if (hyper) begin
        if (hi_nz) mmu_ev[`IEL_M_VA_OOR] = 1'b1;
        else if (x.desc_inv) mmu_ev[`IEL_M_DESC_INV] = 1'b1;
        else if (x.desc_par) mmu_ev[`IEL_M_DESC_PAR] = 1'b1;
        else if (x.va[`IEL_VA_W-1:0] < adj_base) mmu_ev[`IEL_M_ADJ_UF] = 1'b1;
      end
    end
  end
  wire xl_fault = |mmu_ev;
  // Bypass logs raw address, hypervisor translation logs adjusted one
  wire [63:0] log_va = (x.bypass || !hyper) ? x.va : adj_va;

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      mmu_sts <= '0;
      fault_addr <= '0;
      fault_sts <= '0;
    end else begin
      mmu_sts <= mmu_ev | (mmu_sts & ~((wr && hit_msts) ? I_PWDATA[`IEL_MMU_W-1:0] : '0));
      if (xl_fault) begin
        fault_addr <= log_va;
        fault_sts <= {9'h000, x.ttype, x.id};
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_XL_PASS <= 1'b0;
      O_XL_ABORT <= 1'b0;
      O_XL_ABORT_READ <= 1'b0;
    end else begin
      O_XL_PASS <= I_XL_VALID && !xl_fault;
      O_XL_ABORT <= xl_fault;
      O_XL_ABORT_READ <= xl_fault && x.is_read;
    end
  end

  // ----------------------------------------------------------------
  // Completion tag SECDED and acknowledge parity
  // ----------------------------------------------------------------
  // Hamming positions 1..12 plus overall parity in bit 0
  function automatic logic [`IEL_COMPLETION_TAG_FIELD_SW-1:0] completion_tag_field_syn(input logic [`IEL_COMPLETION_TAG_FIELD_W-1:0] c);
    logic [`IEL_COMPLETION_TAG_FIELD_SW-1:0] s;
    s = '0;
    for (int p = 1; p < `IEL_COMPLETION_TAG_FIELD_W; p++) begin
      for (int k = 0; k < `IEL_COMPLETION_TAG_FIELD_SW; k++) begin
        if (p[k]) s[k] = s[k] ^ c[p];
      end
    end
    return s;
  endfunction

  wire [`IEL_COMPLETION_TAG_FIELD_SW-1:0] syn = completion_tag_field_syn(I_COMPLETION_TAG_FIELD_CODE);
  wire par_bad = ^I_COMPLETION_TAG_FIELD_CODE;
  wire completion_tag_field_ce = I_COMPLETION_TAG_FIELD_VALID && par_bad;
  wire completion_tag_field_ue = I_COMPLETION_TAG_FIELD_VALID && !par_bad && (syn != '0);
  wire [`IEL_COMPLETION_TAG_FIELD_W-1:0] fixed = I_COMPLETION_TAG_FIELD_CODE ^ (`IEL_COMPLETION_TAG_FIELD_W'(1) << syn);
  wire [`IEL_TAG_W-1:0] tag_data = {fixed[12:9], fixed[7:5], fixed[3]};
  wire ack_bad = I_ACK_VALID && ((^I_ACK_DATA) != I_ACK_PARITY);

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_COMPLETION_TAG_FIELD_VALID <= 1'b0;
      O_COMPLETION_TAG_FIELD <= '0;
      O_COMPLETION_TAG_FIELD_CREDIT <= 1'b0;
      O_HUB_CE <= 1'b0;
      O_HUB_UE <= 1'b0;
      O_ACK_CREDIT <= 1'b0;
      O_HUB_ACK_ERR <= 1'b0;
      fatal <= '0;
    end else begin
      O_COMPLETION_TAG_FIELD_VALID <= I_COMPLETION_TAG_FIELD_VALID && !completion_tag_field_ue;
      O_COMPLETION_TAG_FIELD_CREDIT <= I_COMPLETION_TAG_FIELD_VALID && !completion_tag_field_ue;
      O_COMPLETION_TAG_FIELD <= tag_data;
      O_HUB_CE <= completion_tag_field_ce;
      O_HUB_UE <= completion_tag_field_ue;
      O_ACK_CREDIT <= I_ACK_VALID && !ack_bad;
      O_HUB_ACK_ERR <= ack_bad;
      // Fatal holds until warm reset
      fatal <= fatal | {ack_bad, completion_tag_field_ue};
    end
  end

  // ----------------------------------------------------------------
  // Software registers and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl <= `IEL_CTRL_RESET;
      imu_mask <= '0;
      mmu_mask <= '0;
      adj_base <= '0;
      eq_en <= '0;
    end else if (wr) begin
      if (hit_ctrl) ctrl <= I_PWDATA;
      if (hit_imask) imu_mask <= I_PWDATA[`IEL_IMU_W-1:0];
      if (hit_mmask) mmu_mask <= I_PWDATA[`IEL_MMU_W-1:0];
      if (hit_base) adj_base <= {8'h00, I_PWDATA};
      if (hit_eq) eq_en <= I_PWDATA[`IEL_EQ_N-1:0];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |((imu_pri | imu_sec) & imu_mask) || |(mmu_sts & mmu_mask);
    end
  end
  assign O_FATAL = |fatal;

  // Zero-wait slave; unmapped addresses answer with an error
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc && !mapped;
  always_comb begin
    case (I_PADDR)
      `IEL_OFF_IMU_PRI: O_PRDATA = 32'(imu_pri);
      `IEL_OFF_IMU_SEC: O_PRDATA = 32'(imu_sec);
      `IEL_OFF_IMU_MASK: O_PRDATA = 32'(imu_mask);
      `IEL_OFF_CTRL: O_PRDATA = ctrl;
      `IEL_OFF_EQ: O_PRDATA = {16'h0000, eq_err, eq_en};
      `IEL_OFF_MMU_STS: O_PRDATA = 32'(mmu_sts);
      `IEL_OFF_MMU_MASK: O_PRDATA = 32'(mmu_mask);
      `IEL_OFF_FADDR_LO: O_PRDATA = fault_addr[31:0];
      `IEL_OFF_FADDR_HI: O_PRDATA = fault_addr[63:32];
      `IEL_OFF_FSTS: O_PRDATA = fault_sts;
      `IEL_OFF_RDS0: O_PRDATA = {rds_log.req_id, rds_log.tag, rds_log.ttype};
      `IEL_OFF_RDS1: O_PRDATA = {14'h0000, rds_log.be, rds_log.len};
      `IEL_OFF_RDS2: O_PRDATA = rds_log.data;
      `IEL_OFF_SCS0: O_PRDATA = {scs_log.req_id, scs_log.tag, scs_log.ttype};
      `IEL_OFF_SCS1: O_PRDATA = {14'h0000, scs_log.be, scs_log.len};
      `IEL_OFF_SCS2: O_PRDATA = scs_log.data;
      `IEL_OFF_ADJ_BASE: O_PRDATA = adj_base[31:0];
      `IEL_OFF_FATAL: O_PRDATA = 32'(fatal);
      default: O_PRDATA = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);

  sequence s_msi_off;
    I_IMU_VALID && t.is_msi && !ctrl[`IEL_C_MSI_EN];
  endsequence

  property p_completion_tag_field_ue_drop;
    completion_tag_field_ue |=> !O_COMPLETION_TAG_FIELD_CREDIT && !O_COMPLETION_TAG_FIELD_VALID && O_HUB_UE && O_FATAL;
  endproperty
  a_completion_tag_field_ue_drop: assert property (p_completion_tag_field_ue_drop) else $error("uncorrectable tag not dropped");

  property p_fatal_sticky;
    O_FATAL |=> O_FATAL;
  endproperty
  a_fatal_sticky: assert property (p_fatal_sticky) else $error("fatal flag fell before reset");

  property p_ack_drop;
    ack_bad |=> !O_ACK_CREDIT && O_HUB_ACK_ERR ##1 O_FATAL;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("bad acknowledge returned credit");

  property p_msi_off_pri;
    s_msi_off ##0 !imu_pri[`IEL_B_MSI_OFF] |=> imu_pri[`IEL_B_MSI_OFF] && !$rose(imu_sec[`IEL_B_MSI_OFF]);
  endproperty
  a_msi_off_pri: assert property (p_msi_off_pri) else $error("MSI disabled primary not set");

  property p_secondary;
    s_msi_off ##0 imu_pri[`IEL_B_MSI_OFF] |=> imu_sec[`IEL_B_MSI_OFF];
  endproperty
  a_secondary: assert property (p_secondary) else $error("secondary bit not set on recurrence");

  property p_null_out;
    I_IMU_VALID && imu_rej |=> O_IMU_VALID && O_IMU_TXN.is_null;
  endproperty
  a_null_out: assert property (p_null_out) else $error("rejected item not sent as null");

  property p_eq_ovf;
    imu_ev[`IEL_B_EQ_OVF] |=> eq_err[$past(t.eq)] && $stable(rds_log) && $stable(scs_log);
  endproperty
  a_eq_ovf: assert property (p_eq_ovf) else $error("overflow did not move queue to error");

  property p_xl_abort;
    xl_fault && x.is_read |=> O_XL_ABORT && O_XL_ABORT_READ && !O_XL_PASS;
  endproperty
  a_xl_abort: assert property (p_xl_abort) else $error("faulting read not aborted");

  property p_irq;
    (|(mmu_sts & mmu_mask)) |=> O_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked error raised no interrupt");

endmodule

// file: dv/iel_ret_model.sv
/*
  Return path model: encodes a tag into the 13-bit protected code,
  with optional bit flips. Assumes the block's rising-edge clock.
*/
module iel_ret_model (
  // Clock
  input wire logic i_clk,
  // Command
  input wire logic i_go,
  input wire logic [7:0] i_tag,
  input wire logic [12:0] i_flip,
  // Return path
  output logic o_valid = 1'b0,
  output logic [12:0] o_code = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] c;
  always_comb begin
    c = '0;
    {c[12], c[11], c[10], c[9], c[7], c[6], c[5], c[3]} = i_tag;
    c[1] = c[3] ^ c[5] ^ c[7] ^ c[9] ^ c[11];
    c[2] = c[3] ^ c[6] ^ c[7] ^ c[10] ^ c[11];
    c[4] = c[5] ^ c[6] ^ c[7] ^ c[12];
    c[8] = c[9] ^ c[10] ^ c[11] ^ c[12];
    c[0] = ^c[12:1];
  end
  // Idle code toggles so a stale code never looks valid
  always @(posedge i_clk) begin
    o_valid <= i_go;
    o_code <= i_go ? c ^ i_flip : ~o_code;
  end
endmodule

// file: dv/tb_iel_error_log.sv
/*
  Self-checking bench of the error detect and log block.
  Assumes the package and defines header are compiled first.
*/
module tb_iel_error_log;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, ack_p = 1'b0, go = 1'b0;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, rd, prd;
  logic [2:0] v = '0;
  logic [7:0] tg = '0, completion_tag_field;
  logic [12:0] fl = '0, cc;
  logic er, cv, prdy, pse, ov, cva, ccr, hce, hue, acr, aer, xp, xa, xar, irq, fat;
  iel_pkg::iel_imu_txn_type it = {1'b1, 3'h5, 6'h00, 8'h78, 10'h004, 16'h1234, 8'h56, 8'h0F, 32'hCAFE_F00D};
  iel_pkg::iel_xl_req_type xr = '0;
  iel_pkg::iel_imu_out_type ot;
  iel_pkg::iel_msg_type mc[5] = '{iel_pkg::IEL_MSG_COR, iel_pkg::IEL_MSG_NONFATAL,
    iel_pkg::IEL_MSG_FATAL, iel_pkg::IEL_MSG_PME, iel_pkg::IEL_MSG_PMEACK};
  int bt[5] = '{1, 2, 3, 1, 5};
  int error_cnt = 0, checks = 0;

  iel_ret_model iel_ret_model_inst (.i_clk(clk), .i_go(go), .i_tag(tg), .i_flip(fl), .o_valid(cv), .o_code(cc));
  iel_error_log iel_error_log_inst (.I_MCLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(pse),
    .I_IMU_VALID(v[0]), .I_IMU_TXN(it), .O_IMU_VALID(ov), .O_IMU_TXN(ot), .I_COMPLETION_TAG_FIELD_VALID(cv),
    .I_COMPLETION_TAG_FIELD_CODE(cc), .O_COMPLETION_TAG_FIELD_VALID(cva), .O_COMPLETION_TAG_FIELD(completion_tag_field), .O_COMPLETION_TAG_FIELD_CREDIT(ccr), .O_HUB_CE(hce),
    .O_HUB_UE(hue), .I_ACK_VALID(v[1]), .I_ACK_DATA(8'h5A), .I_ACK_PARITY(ack_p), .O_ACK_CREDIT(acr),
    .O_HUB_ACK_ERR(aer), .I_XL_VALID(v[2]), .I_XL_REQ(xr), .O_XL_PASS(xp), .O_XL_ABORT(xa),
    .O_XL_ABORT_READ(xar), .O_IRQ(irq), .O_FATAL(fat));

  initial begin
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task conclude;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Waits on pready, bounded so a dead slave ends the run
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 16);
    if (prdy !== 1'b1) begin
      error_cnt++;
      conclude();
    end
    rd = prd;
    er = pse;
    {psel, pen} <= 2'b00;
  endtask
  task ev(input logic [2:0] m);
    @(posedge clk);
    v <= m;
    @(posedge clk);
    v <= 3'b000;
    @(negedge clk);
  endtask
  task ctg(input logic [7:0] t, input logic [12:0] f);
    @(posedge clk);
    {go, tg, fl} <= {1'b1, t, f};
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask
  // One translation request, then its pass or abort answer
  task xl(input iel_pkg::iel_xl_req_type r, input logic [2:0] e);
    @(posedge clk);
    xr <= r;
    ev(3'b100);
    chk({xp, xa, xar}, 32'(e));
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, 12'hFF0, '0);
    chk({rd[30:0], er}, 32'h0000_0001);
    apb(1, 12'h008, 32'h0000_0001);
    ev(3'b001);
    chk({ov, ot.is_null}, 32'h0000_0003);
    apb(0, 12'h000, '0);
    chk({rd[30:0], irq}, 32'h0000_0003);
    apb(0, 12'h028, '0);
    chk(rd, 32'h1234_5678);
    ev(3'b001);
    apb(0, 12'h004, '0);
    chk(rd, 32'h0000_0001);
    apb(1, 12'h000, 32'h0000_0001);
    apb(1, 12'h004, 32'h0000_0001);
    apb(0, 12'h000, '0);
    chk({rd[30:0], irq}, '0);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      it.is_msi <= 1'b0;
      it.msg <= mc[i];
      ev(3'b001);
      apb(0, 12'h000, '0);
      chk(rd, 32'h0000_0001 << bt[i]);
      apb(1, 12'h000, rd);
    end
    apb(1, 12'h00C, 32'h0000_0001);
    it.is_msi <= 1'b1;
    it.par_err <= 1'b1;
    ev(3'b001);
    apb(0, 12'h000, '0);
    chk(rd, 32'h0000_0040);
    apb(1, 12'h000, rd);
    it.par_err <= 1'b0;
    ev(3'b001);
    chk({ov, ot.is_null}, 32'h0000_0003);
    apb(0, 12'h000, '0);
    chk(rd, 32'h0000_0100);
    apb(0, 12'h034, '0);
    chk(rd, 32'h1234_5678);
    it.malformed <= 1'b1;
    ev(3'b001);
    apb(0, 12'h030, '0);
    chk(rd, 32'hCAFE_F00D);
    it.malformed <= 1'b0;
    it.eq_ovf <= 1'b1;
    apb(1, 12'h010, 32'h0000_0001);
    ev(3'b001);
    chk({ov, ot.is_null}, 32'h0000_0003);
    apb(0, 12'h010, '0);
    chk(rd, 32'h0000_0101);
    apb(0, 12'h000, '0);
    chk(rd, 32'h0000_0380);
    ev(3'b010);
    chk({acr, aer, fat}, 32'h0000_0004);
    @(posedge clk);
    ack_p <= 1'b1;
    ev(3'b010);
    chk({acr, aer, fat}, 32'h0000_0003);
    ctg(8'hA5, '0);
    chk({cva, ccr, hce, hue, completion_tag_field}, 32'h0000_0CA5);
    ctg(8'h3C, 13'h0020);
    chk({cva, ccr, hce, hue, completion_tag_field}, 32'h0000_0E3C);
    ctg(8'h3C, 13'h0006);
    chk({cva, ccr, hce, hue}, 32'h0000_0001);
    apb(0, 12'h044, '0);
    chk(rd, 32'h0000_0003);
    @(posedge clk);
    xr <= {64'h0000_0000_1234_5000, 16'h0042, 7'h05, 2'b11, 2'b00};
    ev(3'b100);
    chk({xp, xa, xar}, 32'h0000_0003);
    apb(0, 12'h014, '0);
    chk(rd, 32'h0000_0001);
    apb(0, 12'h01C, '0);
    chk(rd, 32'h1234_5000);
    apb(0, 12'h024, '0);
    chk(rd, 32'h0005_0042);
    apb(1, 12'h00C, 32'h0000_0300);
    xr <= {64'h0000_0100_0000_0000, 16'h0042, 7'h05, 4'b0000};
    ev(3'b100);
    chk({xp, xa, xar}, 32'h0000_0002);
    apb(0, 12'h014, '0);
    chk(rd, 32'h0000_0011);
    apb(1, 12'h018, 32'h0000_003F);
    apb(0, 12'h014, '0);
    chk({rd[30:0], irq}, 32'h0000_0023);
    apb(1, 12'h014, rd);
    xl({64'h0000_0000_0000_2000, 16'h0042, 7'h05, 4'b1010}, 3'b011);
    xl({64'h0000_0000_0000_2000, 16'h0042, 7'h05, 4'b0001}, 3'b010);
    apb(1, 12'h040, 32'h0001_0000);
    xl({64'h0000_0000_0000_8000, 16'h0042, 7'h05, 4'b0000}, 3'b010);
    apb(0, 12'h01C, '0);
    chk(rd, 32'hFFFF_8000);
    apb(1, 12'h00C, 32'h0000_0100);
    xl({64'h0000_0100_0000_0000, 16'h0042, 7'h05, 4'b0100}, 3'b010);
    apb(0, 12'h014, '0);
    chk(rd, 32'h0000_002E);
    // Warm reset is the only way out of a fatal state
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, 12'h044, '0);
    chk({rd[30:0], fat}, '0);
    conclude();
  end
endmodule
